// *** design/relay_vote_pkg.sv ***
package relay_vote_pkg;

    // Sizes of the condition matrix
    localparam int CONDS_PER_IN = 6;
    localparam int MAX_CONDS = 256;
    localparam int CNT_W = 9;
    localparam int COMMON_OUTS = 8;
    localparam int DEF_NUM_IN = 8;
    localparam int DEF_NUM_OUT = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 8;
    localparam logic [SEL_W-1:0] FIRST_USER = 8'h08;

    // Condition bit positions within one input's group
    localparam int COND_LEVEL_LSB = 0;
    localparam int COND_LEVEL_W = 4;
    localparam int COND_FAIL_BIT = 4;
    localparam int COND_INH_BIT = 5;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_SELECT = 8'h00;
    localparam logic [ADDR_W-1:0] REG_COND = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SETUP = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CMD = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h14;

    // Field positions
    localparam int SEL_OUT_LSB = 0;
    localparam int SEL_CH_LSB = 8;
    localparam int SETUP_VOTE_LSB = 0;
    localparam int SETUP_MODE_BIT = 16;
    localparam int SETUP_NEWAL_BIT = 17;
    localparam int CMD_OK_BIT = 0;
    localparam int CMD_CANCEL_BIT = 1;
    localparam int CMD_CLEAR_BIT = 2;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_CFG_BIT = 9;
    localparam int STAT_WARN_BIT = 10;
    localparam int ACT_CNT_LSB = 0;
    localparam int ACT_SET_BIT = 16;

    // Reset values
    localparam logic [CNT_W-1:0] VOTE_RST = 9'h000;
    localparam logic MODE_RST = 1'b0;
    localparam logic NEWAL_RST = 1'b0;

    // Number of true bits in a condition vector
    function automatic logic [CNT_W-1:0] count_ones(input logic [MAX_CONDS-1:0] v);
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < MAX_CONDS; i++) begin
            n = n + CNT_W'(v[i]);
        end
        return n;
    endfunction

endpackage

// *** design/cond_bus_if.sv ***
// Live condition vector shared by the gatherer and every voter
interface cond_bus_if #(
    parameter int W = 48
);
    logic [W-1:0] cond;

    modport src (output cond);
    modport sink (input cond);
endinterface

// *** design/cond_gather.sv ***
module cond_gather
    import relay_vote_pkg::*;
#(
    parameter int NUM_IN = DEF_NUM_IN
) (
    input logic [NUM_IN*COND_LEVEL_W-1:0] alarm_active,
    input logic [NUM_IN-1:0] fault,
    input logic [NUM_IN-1:0] inhibited,
    cond_bus_if.src cb
);

    ////////////////////////////////////////////////////////////////////////
    // One group of six conditions per input
    for (genvar i = 0; i < NUM_IN; i++) begin : g_in
        // Four alarm levels
        assign cb.cond[i*CONDS_PER_IN+COND_LEVEL_LSB +: COND_LEVEL_W] =
            alarm_active[i*COND_LEVEL_W +: COND_LEVEL_W];
        assign cb.cond[i*CONDS_PER_IN+COND_FAIL_BIT] = fault[i];
        assign cb.cond[i*CONDS_PER_IN+COND_INH_BIT] = inhibited[i];
    end

endmodule // cond_gather

// *** design/vote_eval.sv ***
module vote_eval
    import relay_vote_pkg::*;
#(
    parameter int COND_W = 48
) (
    input logic [COND_W-1:0] mask,
    input logic [CNT_W-1:0] vote,
    cond_bus_if.sink cb,
    output logic met,
    output logic [CNT_W-1:0] count
);

    ////////////////////////////////////////////////////////////////////////
    // n-out-of-m: count true selected conditions, compare with n
    always_comb begin
        count = count_ones(MAX_CONDS'(cb.cond & mask));
        met = (vote != VOTE_RST) && (count >= vote);
    end

endmodule // vote_eval

// *** design/relay_output_voting_logic.sv ***
// How it works
// - Any of an input's four alarm levels may be selected per relay output.
// - A selected fail condition counts as true while that input reports a fault.
// - A selected inhibit condition counts as true while that input is inhibited.
// - Up to 256 selected conditions per relay output across all inputs; here six per input, 48 with the default eight inputs.
// - Output sets when true selected conditions reach vote n; 1 is OR, m is AND.
// - Selected-condition count m is readable for comparison with the vote.
// - OK rejects a vote above m, keeps old settings, raises a warning.
// - Normally energised mode drives the relay low while set.
// - Normally de-energised mode drives the relay high while set.
// - With new-alarm on, acknowledge returns the output to normal despite alarm.
// - First eight outputs carry common messages; user setup starts at output nine.
// - Clear erases all parameters of the selected output.
// - Cancel drops pending settings and leaves active ones untouched.
// - Stored parameters stay until explicitly cleared, present or not; here reset also erases them.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
module relay_output_voting_logic
    import relay_vote_pkg::*;
#(
    parameter int NUM_IN = DEF_NUM_IN,
    parameter int NUM_OUT = DEF_NUM_OUT
) (
    input logic clk,
    input logic reset,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wdata,
    input logic wr_en,
    input logic rd_en,
    output logic [DATA_W-1:0] rdata,
    input logic [NUM_IN*COND_LEVEL_W-1:0] alarm_active,
    input logic [NUM_IN-1:0] fault,
    input logic [NUM_IN-1:0] inhibited,
    input logic [COMMON_OUTS-1:0] common_msg,
    input logic acknowledge_key,
    input logic auth_valid,
    output logic [NUM_OUT-1:0] relay_drive,
    output logic warning
);

    localparam int COND_W = NUM_IN * CONDS_PER_IN;
    localparam int OUT_IDX_W = $clog2(NUM_OUT);
    localparam logic [SEL_W-1:0] OUT_LIMIT = SEL_W'(NUM_OUT);
    localparam logic [SEL_W-1:0] CH_LIMIT = SEL_W'(NUM_IN);

    // Selection and pending (uncommitted) settings
    logic [SEL_W-1:0] sel_out_q, sel_out_d, sel_ch_q, sel_ch_d;
    logic [COND_W-1:0] pend_mask_q, pend_mask_d;
    logic [CNT_W-1:0] pend_vote_q, pend_vote_d;
    logic pend_mode_q, pend_mode_d, pend_nal_q, pend_nal_d;
    logic warn_q, warn_d;
    // Committed per-output parameters
    logic [COND_W-1:0] mask_q [NUM_OUT];
    logic [COND_W-1:0] mask_d [NUM_OUT];
    logic [CNT_W-1:0] vote_q [NUM_OUT];
    logic [CNT_W-1:0] vote_d [NUM_OUT];
    logic [NUM_OUT-1:0] mode_q, mode_d, nal_q, nal_d, cfg_q, cfg_d;
    // Live output state
    logic [NUM_OUT-1:0] ackm_q, ackm_d, relay_q, relay_d, met;
    logic [CNT_W-1:0] true_cnt [NUM_OUT];
    logic [DATA_W-1:0] rdata_q, rdata_d;

    logic [OUT_IDX_W-1:0] sel_idx, new_idx;
    logic [CNT_W-1:0] pend_count;
    logic sel_user, new_cfg, vote_ok, auth_ok;
    logic do_ok, do_cancel, do_clear, commit, ok_fail, clr_fail;

    ////////////////////////////////////////////////////////////////////////
    // Condition sources and one voter per output
    cond_bus_if #(.W(COND_W)) cbus ();

    cond_gather #(.NUM_IN(NUM_IN)) i_cond_gather (
        .alarm_active(alarm_active),
        .fault(fault),
        .inhibited(inhibited),
        .cb(cbus.src)
    );

    for (genvar o = 0; o < NUM_OUT; o++) begin : g_vote
        vote_eval #(.COND_W(COND_W)) i_vote_eval (
            .mask(mask_q[o]),
            .vote(vote_q[o]),
            .cb(cbus.sink),
            .met(met[o]),
            .count(true_cnt[o])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode and validity checks
    assign sel_idx = sel_out_q[OUT_IDX_W-1:0];
    assign new_idx = wdata[SEL_OUT_LSB +: OUT_IDX_W];
    assign new_cfg = (wdata[SEL_OUT_LSB +: SEL_W] < OUT_LIMIT) && cfg_q[new_idx];
    assign sel_user = (sel_out_q >= FIRST_USER) && (sel_out_q < OUT_LIMIT);
    assign pend_count = count_ones(MAX_CONDS'(pend_mask_q));
    assign vote_ok = (pend_vote_q != VOTE_RST) && (pend_vote_q <= pend_count);
    // Unconfigured outputs need the operator's authorisation
    assign auth_ok = sel_user && (cfg_q[sel_idx] || auth_valid);
    assign do_ok = wr_en && (addr == REG_CMD) && wdata[CMD_OK_BIT];
    assign do_cancel = wr_en && (addr == REG_CMD) && wdata[CMD_CANCEL_BIT];
    assign do_clear = wr_en && (addr == REG_CMD) && wdata[CMD_CLEAR_BIT];
    // Clear outranks cancel, cancel outranks OK
    assign commit = do_ok && !do_clear && !do_cancel && auth_ok && vote_ok;
    assign ok_fail = do_ok && !do_clear && !do_cancel && !(auth_ok && vote_ok);
    assign clr_fail = do_clear && !sel_user; // Common outputs stay fixed

    ////////////////////////////////////////////////////////////////////////
    // Next values of selection, pending and stored parameters
    always_comb begin
        sel_out_d = sel_out_q;
        sel_ch_d = sel_ch_q;
        pend_mask_d = pend_mask_q;
        pend_vote_d = pend_vote_q;
        pend_mode_d = pend_mode_q;
        pend_nal_d = pend_nal_q;
        warn_d = warn_q;
        mode_d = mode_q;
        nal_d = nal_q;
        cfg_d = cfg_q;
        for (int o = 0; o < NUM_OUT; o++) begin
            mask_d[o] = mask_q[o];
            vote_d[o] = vote_q[o];
        end
        // A new selection shows its stored setup; unconfigured keeps the last as a copy
        if (wr_en && addr == REG_SELECT) begin
            sel_out_d = wdata[SEL_OUT_LSB +: SEL_W];
            sel_ch_d = wdata[SEL_CH_LSB +: SEL_W];
            if (new_cfg) begin
                pend_mask_d = mask_q[new_idx];
                pend_vote_d = vote_q[new_idx];
                pend_mode_d = mode_q[new_idx];
                pend_nal_d = nal_q[new_idx];
            end
        end
        // Condition boxes for the chosen input
        if (wr_en && addr == REG_COND && sel_ch_q < CH_LIMIT) begin
            pend_mask_d[int'(sel_ch_q)*CONDS_PER_IN +: CONDS_PER_IN] =
                wdata[CONDS_PER_IN-1:0];
        end
        if (wr_en && addr == REG_SETUP) begin
            pend_vote_d = wdata[SETUP_VOTE_LSB +: CNT_W];
            pend_mode_d = wdata[SETUP_MODE_BIT];
            pend_nal_d = wdata[SETUP_NEWAL_BIT];
        end
        if (do_clear && sel_user) begin
            // Back to the never-configured state
            mask_d[sel_idx] = '0;
            vote_d[sel_idx] = VOTE_RST;
            mode_d[sel_idx] = MODE_RST;
            nal_d[sel_idx] = NEWAL_RST;
            cfg_d[sel_idx] = 1'b0;
        end else if (do_cancel && sel_user) begin
            // Pending edits dropped, stored ones untouched
            pend_mask_d = mask_q[sel_idx];
            pend_vote_d = vote_q[sel_idx];
            pend_mode_d = mode_q[sel_idx];
            pend_nal_d = nal_q[sel_idx];
        end else if (commit) begin
            mask_d[sel_idx] = pend_mask_q;
            vote_d[sel_idx] = pend_vote_q;
            mode_d[sel_idx] = pend_mode_q;
            nal_d[sel_idx] = pend_nal_q;
            cfg_d[sel_idx] = 1'b1;
        end
        // Write-one-to-clear, but a new refusal in the same cycle wins
        if (wr_en && addr == REG_STATUS && wdata[STAT_WARN_BIT]) begin
            warn_d = 1'b0;
        end
        if (ok_fail || clr_fail) begin
            warn_d = 1'b1;
        end
    end

    // Stored parameters change only on reset, commit or clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_out_q <= FIRST_USER;
            sel_ch_q <= '0;
            pend_mask_q <= '0;
            pend_vote_q <= VOTE_RST;
            pend_mode_q <= MODE_RST;
            pend_nal_q <= NEWAL_RST;
            warn_q <= 1'b0;
            mode_q <= '0;
            nal_q <= '0;
            cfg_q <= '0;
            for (int o = 0; o < NUM_OUT; o++) begin
                mask_q[o] <= '0;
                vote_q[o] <= VOTE_RST;
            end
        end else begin
            sel_out_q <= sel_out_d;
            sel_ch_q <= sel_ch_d;
            pend_mask_q <= pend_mask_d;
            pend_vote_q <= pend_vote_d;
            pend_mode_q <= pend_mode_d;
            pend_nal_q <= pend_nal_d;
            warn_q <= warn_d;
            mode_q <= mode_d;
            nal_q <= nal_d;
            cfg_q <= cfg_d;
            for (int o = 0; o < NUM_OUT; o++) begin
                mask_q[o] <= mask_d[o];
                vote_q[o] <= vote_d[o];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge masking and relay drive levels
    always_comb begin
        for (int o = 0; o < NUM_OUT; o++) begin
            // Mask holds only while the vote is still met, so a fresh alarm re-sets
            ackm_d[o] = met[o] && (ackm_q[o] || (acknowledge_key && nal_q[o]));
            if (o < COMMON_OUTS) begin
                relay_d[o] = common_msg[o];
            end else if (mode_q[o]) begin
                relay_d[o] = !(met[o] && !ackm_q[o]);
            end else begin
                relay_d[o] = met[o] && !ackm_q[o];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ackm_q <= '0;
            relay_q <= '0;
        end else begin
            ackm_q <= ackm_d;
            relay_q <= relay_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port, data valid the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (rd_en) begin
            case (addr)
                REG_SELECT: begin
                    rdata_d[SEL_OUT_LSB +: SEL_W] = sel_out_q;
                    rdata_d[SEL_CH_LSB +: SEL_W] = sel_ch_q;
                end
                REG_COND: begin
                    if (sel_ch_q < CH_LIMIT) begin
                        rdata_d[CONDS_PER_IN-1:0] =
                            pend_mask_q[int'(sel_ch_q)*CONDS_PER_IN +: CONDS_PER_IN];
                    end
                end
                REG_SETUP: begin
                    rdata_d[SETUP_VOTE_LSB +: CNT_W] = pend_vote_q;
                    rdata_d[SETUP_MODE_BIT] = pend_mode_q;
                    rdata_d[SETUP_NEWAL_BIT] = pend_nal_q;
                end
                REG_STATUS: begin
                    rdata_d[STAT_CNT_LSB +: CNT_W] = pend_count;
                    rdata_d[STAT_CFG_BIT] = sel_user && cfg_q[sel_idx];
                    rdata_d[STAT_WARN_BIT] = warn_q;
                end
                REG_ACTIVE: begin
                    if (sel_out_q < OUT_LIMIT) begin
                        rdata_d[ACT_CNT_LSB +: CNT_W] = true_cnt[sel_idx];
                        rdata_d[ACT_SET_BIT] = met[sel_idx] && !ackm_q[sel_idx];
                    end
                end
                default: rdata_d = '0; // Unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign relay_drive = relay_q;
    assign warning = warn_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (reset);

    a_bad_vote_refused: assert property (
        (do_ok && !do_clear && !do_cancel && sel_user && pend_vote_q > pend_count)
        |=> (warn_q && $stable(cfg_q) && vote_q[$past(sel_idx)] == $past(vote_q[sel_idx])))
        else $error("vote above selected count was not refused");

    a_good_vote_commit: assert property (
        commit |=> (cfg_q[$past(sel_idx)] && vote_q[$past(sel_idx)] == $past(pend_vote_q)))
        else $error("valid settings were not committed");

    a_clear_erases: assert property (
        (do_clear && sel_user) |=> (!cfg_q[$past(sel_idx)] && vote_q[$past(sel_idx)] == VOTE_RST))
        else $error("clear left parameters behind");

    a_cancel_restores: assert property (
        (do_cancel && !do_clear && sel_user)
        |=> (pend_vote_q == $past(vote_q[sel_idx]) && $stable(cfg_q)))
        else $error("cancel changed stored setup or kept pending edits");

    a_common_locked: assert property (
        (do_ok && !do_clear && !do_cancel && sel_out_q < FIRST_USER) |=> (warn_q && $stable(cfg_q)))
        else $error("common message output accepted a setup");

    a_count_readback: assert property (
        (rd_en && addr == REG_STATUS) |=> rdata[STAT_CNT_LSB +: CNT_W] == $past(pend_count))
        else $error("selected count read back wrong");

    for (genvar o = COMMON_OUTS; o < NUM_OUT; o++) begin : g_chk
        a_energised_low: assert property (
            (met[o] && !ackm_q[o] && mode_q[o]) |=> !relay_drive[o])
            else $error("energised output not low while set");

        a_deenergised_high: assert property (
            (met[o] && !ackm_q[o] && !mode_q[o]) |=> relay_drive[o])
            else $error("de-energised output not high while set");

        a_ack_release: assert property (
            (acknowledge_key && nal_q[o] && met[o] && $stable(mode_q[o]) ##1 met[o])
            |=> relay_drive[o] == mode_q[o])
            else $error("acknowledge did not return output to normal");
    end

endmodule // relay_output_voting_logic

// *** bench/relay_coil_model.sv ***
////////////////////////////////////////////////////////////////////////////////
// Relay driver stage with its coil: the coil follows the drive level one clock
// later, which stands in for the driver's switching delay.
module relay_coil_model #(
    parameter int N = 16
) (
    input logic clk,
    input logic reset,
    input logic [N-1:0] drive,
    output logic [N-1:0] coil_on
);
    timeunit 1ns;
    timeprecision 1ns;

    // A high drive level energises the coil; reset drops every coil
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            coil_on <= '0;
        end else begin
            coil_on <= drive;
        end
    end
endmodule // relay_coil_model

// *** bench/tb_relay_output_voting_logic.sv ***
////////////////////////////////////////////////////////////////////////////////
module tb_relay_output_voting_logic import relay_vote_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int NI = DEF_NUM_IN;
    localparam int NO = DEF_NUM_OUT;
    localparam logic [DATA_W-1:0] OK_CMD = DATA_W'(1) << CMD_OK_BIT;
    localparam logic [DATA_W-1:0] WARN_CLR = DATA_W'(1) << STAT_WARN_BIT;

    logic clk, reset, wr_en, rd_en, acknowledge_key, auth_valid, warning;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic [NI*COND_LEVEL_W-1:0] alarm_active;
    logic [NI-1:0] fault, inhibited;
    logic [COMMON_OUTS-1:0] common_msg;
    logic [NO-1:0] relay_drive, coil_on;
    int mismatches, num_checks;

    relay_output_voting_logic #(.NUM_IN(NI), .NUM_OUT(NO)) i_relay_output_voting_logic (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .alarm_active(alarm_active), .fault(fault), .inhibited(inhibited),
        .common_msg(common_msg), .acknowledge_key(acknowledge_key), .auth_valid(auth_valid),
        .relay_drive(relay_drive), .warning(warning));

    relay_coil_model #(.N(NO)) i_relay_coil_model (
        .clk(clk), .reset(reset), .drive(relay_drive), .coil_on(coil_on));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("BAD %0t run did not finish", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks; all but check and test_done start just after a rising edge and end on one
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Idle edge after the strobe so back-to-back calls never reassign it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic relay_chk(input int o, input logic e, input string what);
        @(negedge clk);
        check(32'(relay_drive[o]), 32'(e), what);
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic setup_out(input int o, input int ch, input int cond, input int setup);
        wr(REG_SELECT, DATA_W'((ch << SEL_CH_LSB) | (o << SEL_OUT_LSB)));
        wr(REG_COND, DATA_W'(cond));
        wr(REG_SETUP, DATA_W'(setup));
        wr(REG_CMD, OK_CMD);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        mismatches = 0;
        num_checks = 0;
        reset = 1'b1;
        {wr_en, rd_en, acknowledge_key, auth_valid} = 4'h0;
        addr = '0;
        wdata = '0;
        {alarm_active, fault, inhibited} = '0;
        common_msg = '0;
        cyc(3);
        reset <= 1'b0;
        @(negedge clk);
        check(32'(relay_drive), 32'h0, "relay after reset");
        check(32'(warning), 32'h0, "warning after reset");
        @(posedge clk);
        // Common outputs pass straight through; no user setup there
        common_msg <= 8'ha5;
        cyc(1);
        @(negedge clk);
        check(32'(relay_drive[7:0]), 32'ha5, "common outputs");
        @(posedge clk);
        rd(8'h20, v);
        check(v, 32'h0, "unmapped read");
        auth_valid <= 1'b1;
        setup_out(3, 0, 6'h01, 1);
        rd(REG_STATUS, v);
        check(v, 32'h0000_0401, "setup of common output");
        wr(REG_STATUS, WARN_CLR);
        // Unconfigured output needs authorisation, then a vote within m
        auth_valid <= 1'b0;
        setup_out(9, 0, 6'h3f, 6);
        rd(REG_STATUS, v);
        check(v, 32'h0000_0406, "ok without authorisation");
        wr(REG_STATUS, WARN_CLR);
        auth_valid <= 1'b1;
        wr(REG_SETUP, 32'h0000_0007);
        wr(REG_CMD, OK_CMD);
        rd(REG_STATUS, v);
        check(v, 32'h0000_0406, "vote above count");
        wr(REG_STATUS, WARN_CLR);
        wr(REG_SETUP, 32'h0000_0006);
        wr(REG_CMD, OK_CMD);
        rd(REG_STATUS, v);
        check(v, 32'h0000_0206, "commit with count six");
        // Vote of six needs all six; the last one shows after one cycle
        alarm_active[3:0] <= 4'hf;
        fault[0] <= 1'b1;
        cyc(2);
        relay_chk(9, 1'b0, "five of six");
        inhibited[0] <= 1'b1;
        relay_chk(9, 1'b0, "registered one cycle");
        relay_chk(9, 1'b1, "six of six");
        rd(REG_ACTIVE, v);
        check(v, 32'h0001_0006, "active count and set");
        {alarm_active, fault, inhibited} <= '0;
        // Vote of one on input 1: every condition type alone sets the output
        setup_out(10, 1, 6'h3f, 1);
        for (int k = 0; k < CONDS_PER_IN; k++) begin
            if (k < COND_LEVEL_W) alarm_active[COND_LEVEL_W + k] <= 1'b1;
            else if (k == COND_FAIL_BIT) fault[1] <= 1'b1;
            else inhibited[1] <= 1'b1;
            cyc(1);
            relay_chk(10, 1'b1, "single condition");
            {alarm_active, fault, inhibited} <= '0;
            cyc(1);
            relay_chk(10, 1'b0, "condition gone");
        end
        // Energised mode is high at rest and low while set
        wr(REG_SETUP, 32'h0001_0001);
        wr(REG_CMD, OK_CMD);
        relay_chk(10, 1'b1, "energised at rest");
        @(negedge clk);
        check(32'(coil_on[10]), 32'h1, "coil held in");
        @(posedge clk);
        fault[1] <= 1'b1;
        cyc(1);
        relay_chk(10, 1'b0, "energised while set");
        fault[1] <= 1'b0;
        // Cancel brings back the stored setup
        wr(REG_SETUP, 32'h0002_0003);
        wr(REG_CMD, DATA_W'(1) << CMD_CANCEL_BIT);
        rd(REG_SETUP, v);
        check(v, 32'h0001_0001, "cancel restores setup");
        relay_chk(10, 1'b1, "cancel keeps mode");
        // New-alarm option: acknowledge returns the output while alarm holds
        wr(REG_SETUP, 32'h0002_0001);
        wr(REG_CMD, OK_CMD);
        alarm_active[4] <= 1'b1;
        cyc(1);
        relay_chk(10, 1'b1, "de-energised while set");
        acknowledge_key <= 1'b1;
        @(posedge clk);
        acknowledge_key <= 1'b0;
        cyc(1);
        relay_chk(10, 1'b0, "acknowledged");
        alarm_active[4] <= 1'b0;
        cyc(2);
        alarm_active[4] <= 1'b1;
        cyc(1);
        relay_chk(10, 1'b1, "alarm again");
        // Clear erases output 10 only; output 9 keeps its stored setup
        wr(REG_CMD, DATA_W'(1) << CMD_CLEAR_BIT);
        relay_chk(10, 1'b0, "cleared output idle");
        rd(REG_STATUS, v);
        check(v & 32'h0000_0200, 32'h0, "cleared unconfigured");
        wr(REG_SELECT, 32'h0000_0009);
        rd(REG_STATUS, v);
        check(v & 32'h0000_0200, 32'h0000_0200, "other output kept");
        auth_valid <= 1'b0;
        setup_out(10, 1, 6'h01, 1);
        relay_chk(10, 1'b0, "refused setup idle");
        @(negedge clk);
        check(32'(warning), 32'h1, "refused setup warns");
        @(posedge clk);
        alarm_active <= '0;
        cyc(2);
        test_done();
    end
endmodule // tb_relay_output_voting_logic
